// ### usbesu_pkg.sv
// Package of the USB event and status unit: register indices, field positions,
// reset values, timing counts and the serial engine event carrier.
// Assumes a 125 MHz core clock and registers reached over APB at four times their index.
package usbesu_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [9:0] IDX_EVT_FLAGS = 10'h190; // Event flags.
  localparam logic [9:0] IDX_EVT_EN = 10'h191; // Event enables.
  localparam logic [9:0] IDX_ERR_FLAGS = 10'h192; // Error flags.
  localparam logic [9:0] IDX_ERR_EN = 10'h193; // Error enables.
  localparam logic [9:0] IDX_STAT_WIN = 10'h194; // Transaction status window.
  localparam logic [9:0] IDX_CTRL = 10'h195; // Control register.

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int EV_RST = 0; // Bus reset seen.
  localparam int EV_ERR = 1; // Summary error.
  localparam int EV_ACT = 2; // Bus activity.
  localparam int EV_TOK = 3; // Token done.
  localparam int EV_IDLE = 4; // Bus idle.
  localparam int EV_STALL = 5; // Stall handshake sent.
  localparam int ER_PID = 0; // Packet id check failed.
  localparam int ER_CRC5 = 1; // Token CRC failed.
  localparam int ER_CRC16 = 2; // Data CRC failed.
  localparam int ER_LEN = 3; // Partial byte in data field.
  localparam int ER_BTO = 4; // Turnaround timeout.
  localparam int ER_WRT = 5; // Buffer write collision.
  localparam int ER_OWN = 6; // Descriptor ownership error.
  localparam int ER_BTS = 7; // Bit stuffing error.
  localparam int CTRL_SUSP = 1; // Suspend control bit.

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_FLAGS = 8'h00; // Flags, enables, control.
  localparam logic [5:0] EVT_MASK = 6'h3F; // Implemented event bits.

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8; // Core clock period.
  localparam int IDLE_TIME_US = 3000; // Idle detect time, 3 ms.
  localparam int IDLE_CYC = (IDLE_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int RST_TIME_NS = 2500; // Reset detect time, 2.5 us.
  localparam int RST_CYC = (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] BTO_BITS = 5'h11; // Turnaround limit, 17 bit times.
  localparam int FIFO_DEPTH = 4; // Status queue depth.

  // ************************************************************
  // Serial engine event carrier
  // ************************************************************
  typedef struct packed {
    logic reset_lvl; // Reset signalling present on the lines.
    logic idle_lvl; // Lines in the idle state.
    logic activity; // Pulse: activity on the data lines.
    logic stall_sent; // Pulse: stall handshake sent.
    logic tok_start; // Pulse: token processing starts.
    logic desc_owned; // Descriptor owner bit of that token.
    logic tok_done; // Pulse: token complete.
    logic [7:0] tok_stat; // Endpoint and direction of that token.
    logic bitstuff; // Pulse: bit stuffing violation.
    logic eop; // Pulse: end of packet.
    logic bit_tick; // Pulse: one bit time elapsed.
    logic await_turn; // Level: waiting for the next phase.
    logic data_end; // Pulse: data field ended.
    logic [2:0] bit_rem; // Bits past the last whole byte.
    logic crc5_bad; // Pulse: token CRC failed.
    logic crc16_bad; // Pulse: data CRC failed.
    logic pid_vld; // Pulse: packet id received.
    logic [7:0] pid; // Received packet id byte.
    logic buf_wr; // Engine writes a buffer location.
    logic [5:0] buf_addr; // Location the engine writes.
  } usbesu_evt_t;

endpackage

// ### usbesu_top.sv
// Event flags, error flags, interrupt request and status queue of a USB function.
// Assumes a serial engine feeding usbesu_evt_t synchronous to CORE_CLK and an APB master.
//
// Contract
// - enabled event flags OR into one interrupt
// - flags clear only by writing zero
// - flag writes ignored while suspended
// - stall sent sets event bit 5
// - idle 3 ms sets bit 4, activity restarts
// - token done sets bit 3, queues status
// - clearing token done advances queue, may re-set
// - status window backed by four-entry queue
// - line activity sets event bit 2
// - reset after 2.5 us sets bit 0 once
// - enables gate interrupt only, flags still latch
// - enabled error flags OR into summary bit 1
// - bit stuff violation sets error bit 7
// - token on processor-owned descriptor sets bit 6
// - colliding buffer write dropped, sets bit 5
// - over 17 idle bit times sets bit 4
// - partial byte data field sets bit 3
// - bad CRC5 sets bit 1, CRC16 bit 2
// - bad packet id check sets bit 0
// - suspend raises SUSPEND, drops XCVR_OE, only activity interrupts
// - descriptor released before status and token done
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module usbesu_top
  import usbesu_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = IDLE_CYC,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire usbesu_evt_t SE_EVT,
  input wire logic CPU_BUF_WR,
  input wire logic [5:0] CPU_BUF_ADDR,
  output logic BUF_WR_GRANT,
  output logic DESC_RELEASE,
  output logic USB_IRQ,
  output logic SUSPEND,
  output logic XCVR_OE
);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  // The queue pointers wrap by overflow, so the depth must be a power of two.
  if (IDLE_CYCLES < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_bad_param
    $error("usbesu_top: unsupported parameter value");
  end

  localparam int IW = $clog2(IDLE_CYCLES + 1); // Idle counter width.
  localparam int PW = $clog2(DEPTH); // Queue pointer width.

  // ************************************************************
  // Register state
  // ************************************************************
  logic [5:0] evt_r; // Latched event flags; bit 1 is unused here.
  logic [5:0] evt_nxt;
  logic [5:0] evt_en_r; // Event enables.
  logic [7:0] err_r; // Latched error flags.
  logic [7:0] err_nxt;
  logic [7:0] err_en_r; // Error enables.
  logic suspend_r; // Suspend control bit.
  logic sum_err; // Summary error, live from the error flags.
  logic [5:0] evt_view; // Event flags as software reads them.
  logic [7:0] win; // Status window contents, read by the bus slave.

  // Decode of the APB access phase; writes land only at the completing edge.
  logic [9:0] idx;
  logic acc_wr;
  logic wr_evt;
  logic wr_err;
  assign idx = PADDR[11:2];
  assign acc_wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign wr_evt = acc_wr && idx == IDX_EVT_FLAGS;
  assign wr_err = acc_wr && idx == IDX_ERR_FLAGS;

  // ************************************************************
  // APB slave
  // ************************************************************
  // The answer is prepared at the setup edge so that every bus output is a flop;
  // read data is therefore a snapshot one cycle before the access completes.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
    end
    else
    begin
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h0000_0000;
      if (PSEL && !PENABLE)
      begin
        // Unaligned byte addresses are unmapped.
        PSLVERR <= PADDR[1:0] != 2'h0 || idx < IDX_EVT_FLAGS || idx > IDX_CTRL;
        if (!PWRITE)
        begin
          case (idx)
            IDX_EVT_FLAGS: PRDATA[5:0] <= evt_view;
            IDX_EVT_EN: PRDATA[5:0] <= evt_en_r;
            IDX_ERR_FLAGS: PRDATA[7:0] <= err_r;
            IDX_ERR_EN: PRDATA[7:0] <= err_en_r;
            IDX_STAT_WIN: PRDATA[7:0] <= win;
            IDX_CTRL: PRDATA[CTRL_SUSP] <= suspend_r;
            default: PRDATA <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Enable and control registers are plain read/write and are not suspend gated.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      evt_en_r <= RST_FLAGS[5:0];
      err_en_r <= RST_FLAGS;
      suspend_r <= 1'b0;
    end
    else if (acc_wr)
    begin
      if (idx == IDX_EVT_EN)
        evt_en_r <= PWDATA[5:0] & EVT_MASK;
      if (idx == IDX_ERR_EN)
        err_en_r <= PWDATA[7:0];
      if (idx == IDX_CTRL)
        suspend_r <= PWDATA[CTRL_SUSP];
    end
  end

  // ************************************************************
  // Bus condition detectors
  // ************************************************************
  logic [IW-1:0] idle_cnt_r; // Cycles of unbroken idle.
  logic idle_hit; // Idle time just reached.
  assign idle_hit = SE_EVT.idle_lvl && !SE_EVT.activity && idle_cnt_r == IW'(IDLE_CYCLES - 1);

  // Activity or leaving idle restarts the timer; it parks at the limit so one idle
  // period raises the flag once.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      idle_cnt_r <= '0;
    else if (!SE_EVT.idle_lvl || SE_EVT.activity)
      idle_cnt_r <= '0;
    else if (idle_cnt_r != IW'(IDLE_CYCLES))
      idle_cnt_r <= idle_cnt_r + 1'b1;
  end

  logic [8:0] rst_cnt_r; // Cycles of reset signalling.
  logic rst_done_r; // Flag already raised for this reset.
  logic rst_hit;
  assign rst_hit = SE_EVT.reset_lvl && !rst_done_r && rst_cnt_r == 9'(RST_CYC - 1);

  // Re-arms only when the reset signalling goes away.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      rst_cnt_r <= '0;
      rst_done_r <= 1'b0;
    end
    else if (!SE_EVT.reset_lvl)
    begin
      rst_cnt_r <= '0;
      rst_done_r <= 1'b0;
    end
    else if (!rst_done_r)
    begin
      rst_cnt_r <= rst_cnt_r + 1'b1;
      rst_done_r <= rst_hit;
    end
  end

  logic [4:0] bto_cnt_r; // Idle bit times since the last end of packet.
  logic bto_hit;
  assign bto_hit = SE_EVT.bit_tick && SE_EVT.await_turn && SE_EVT.idle_lvl && bto_cnt_r == BTO_BITS;

  // Counts only while a reply phase is awaited and the line still idles.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET || SE_EVT.eop || !SE_EVT.await_turn || !SE_EVT.idle_lvl)
      bto_cnt_r <= '0;
    else if (SE_EVT.bit_tick && bto_cnt_r <= BTO_BITS)
      bto_cnt_r <= bto_cnt_r + 1'b1;
  end

  // ************************************************************
  // Buffer write arbitration
  // ************************************************************
  logic wr_clash;
  assign wr_clash = CPU_BUF_WR && SE_EVT.buf_wr && CPU_BUF_ADDR == SE_EVT.buf_addr;

  // The engine always wins a clash; the processor write is simply not granted.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
      BUF_WR_GRANT <= 1'b0;
    else
      BUF_WR_GRANT <= CPU_BUF_WR && !wr_clash;
  end

  // ************************************************************
  // Token completion and status queue
  // ************************************************************
  logic tok_stage_r; // Descriptor released, status pending.
  logic [7:0] tok_stat_r; // Status held for the push.

  // The descriptor goes back to the processor one cycle before status is queued.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      DESC_RELEASE <= 1'b0;
      tok_stage_r <= 1'b0;
      tok_stat_r <= 8'h00;
    end
    else
    begin
      DESC_RELEASE <= SE_EVT.tok_done;
      tok_stage_r <= SE_EVT.tok_done;
      if (SE_EVT.tok_done)
        tok_stat_r <= SE_EVT.tok_stat;
    end
  end

  logic [7:0] q_mem [DEPTH]; // Queue storage.
  logic [PW-1:0] q_rd_r;
  logic [PW-1:0] q_wr_r;
  logic [PW:0] q_cnt_r;
  logic push;
  logic pop;
  // A full queue drops the newest status; token done is already pending then.
  assign push = tok_stage_r && q_cnt_r != (PW+1)'(DEPTH);
  assign pop = wr_evt && !suspend_r && !PWDATA[EV_TOK] && evt_r[EV_TOK] && q_cnt_r != '0;
  assign win = q_cnt_r != '0 ? q_mem[q_rd_r] : 8'h00;

  for (genvar i = 0; i < DEPTH; i++)
  begin : g_entry
    // Each entry loads only when the write pointer names it.
    always_ff @(posedge CORE_CLK)
    begin
      if (RESET)
        q_mem[i] <= 8'h00;
      else if (push && q_wr_r == PW'(i))
        q_mem[i] <= tok_stat_r;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      q_rd_r <= '0;
      q_wr_r <= '0;
      q_cnt_r <= '0;
    end
    else
    begin
      q_wr_r <= q_wr_r + PW'(push);
      q_rd_r <= q_rd_r + PW'(pop);
      q_cnt_r <= q_cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // ************************************************************
  // Flag registers
  // ************************************************************
  logic [5:0] evt_set;
  logic [7:0] err_set;
  logic refill; // Another status waits after a pop.
  assign refill = pop && (q_cnt_r > (PW+1)'(1) || push);

  // Hardware sets win over a clearing write in the same cycle; a write of one
  // clears nothing, and suspend blocks the clearing writes altogether.
  always_comb
  begin
    evt_set = 6'h00;
    evt_set[EV_RST] = rst_hit;
    evt_set[EV_ACT] = SE_EVT.activity;
    evt_set[EV_TOK] = tok_stage_r || refill;
    evt_set[EV_IDLE] = idle_hit;
    evt_set[EV_STALL] = SE_EVT.stall_sent;
    err_set = 8'h00;
    err_set[ER_PID] = SE_EVT.pid_vld && SE_EVT.pid[7:4] != ~SE_EVT.pid[3:0];
    err_set[ER_CRC5] = SE_EVT.crc5_bad;
    err_set[ER_CRC16] = SE_EVT.crc16_bad;
    err_set[ER_LEN] = SE_EVT.data_end && SE_EVT.bit_rem != 3'h0;
    err_set[ER_BTO] = bto_hit;
    err_set[ER_WRT] = wr_clash;
    err_set[ER_OWN] = SE_EVT.tok_start && !SE_EVT.desc_owned;
    err_set[ER_BTS] = SE_EVT.bitstuff;
    evt_nxt = evt_r;
    err_nxt = err_r;
    if (wr_evt && !suspend_r)
      evt_nxt = evt_r & PWDATA[5:0];
    if (wr_err && !suspend_r)
      err_nxt = err_r & PWDATA[7:0];
    evt_nxt = (evt_nxt | evt_set) & EVT_MASK & ~6'h02;
    err_nxt = err_nxt | err_set;
  end

  // Flags latch independently of their enables so software can poll them.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      evt_r <= RST_FLAGS[5:0];
      err_r <= RST_FLAGS;
    end
    else
    begin
      evt_r <= evt_nxt;
      err_r <= err_nxt;
    end
  end

  assign sum_err = |(err_r & err_en_r);
  assign evt_view = evt_r | {4'h0, sum_err, 1'b0};

  // ************************************************************
  // Interrupt request and suspend outputs
  // ************************************************************
  // In suspend only bus activity may wake the processor.
  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      USB_IRQ <= 1'b0;
      SUSPEND <= 1'b0;
      XCVR_OE <= 1'b0;
    end
    else
    begin
      if (suspend_r)
        USB_IRQ <= evt_view[EV_ACT] && evt_en_r[EV_ACT];
      else
        USB_IRQ <= |(evt_view & evt_en_r);
      SUSPEND <= suspend_r;
      XCVR_OE <= !suspend_r;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  a_irq_gate: assert property ((|(evt_view & evt_en_r)) && !suspend_r |=> USB_IRQ)
    else $error("enabled flag did not raise irq");
  a_flag_hold: assert property (evt_r[EV_STALL] && !(wr_evt && !PWDATA[EV_STALL]) |=> evt_r[EV_STALL])
    else $error("stall flag dropped without clear");
  a_susp_block: assert property (suspend_r && (wr_evt || wr_err) |=> evt_r == (($past(evt_r) | $past(evt_set)) & 6'h3D)
    && err_r == ($past(err_r) | $past(err_set)))
    else $error("flag changed while suspended");
  a_stall_set: assert property (SE_EVT.stall_sent |=> evt_r[EV_STALL])
    else $error("stall flag not set");
  a_tok_order: assert property (SE_EVT.tok_done |=> DESC_RELEASE && !$past(DESC_RELEASE) ##1 evt_r[EV_TOK])
    else $error("release or token done out of order");
  a_rst_once: assert property (rst_done_r && SE_EVT.reset_lvl && !evt_r[EV_RST] |=> !evt_r[EV_RST])
    else $error("bus reset flagged twice");
  a_pid_check: assert property (SE_EVT.pid_vld && SE_EVT.pid == 8'h33 |=> err_r[ER_PID])
    else $error("bad packet id not flagged");
  a_wr_drop: assert property (wr_clash |=> !BUF_WR_GRANT && err_r[ER_WRT])
    else $error("colliding write granted");
  a_err_sum: assert property (err_r[ER_OWN] && err_en_r[ER_OWN] |-> evt_view[EV_ERR])
    else $error("summary error missing");
  a_refill: assert property (pop && q_cnt_r == (PW+1)'(2) && !push |=> evt_r[EV_TOK] && q_cnt_r == (PW+1)'(1))
    else $error("queue did not refill token done");

  c_queue_full: cover property (q_cnt_r == (PW+1)'(DEPTH));
  c_refill: cover property (refill);
  c_wake: cover property (suspend_r && USB_IRQ);

endmodule

// ### usbesu_se_model.sv
// Serial engine stand-in that drives the event carrier of the status unit.
// Assumes the testbench calls its tasks one at a time on the core clock.
`timescale 1ns/1ps
module usbesu_se_model
  import usbesu_pkg::*;
(
  input wire logic clk,
  output usbesu_evt_t se_evt
);
  // ************************************************************
  // Line levels and event pulses
  // ************************************************************
  usbesu_evt_t lvl_r; // Levels held between pulses.

  // Quiet lines at time zero.
  initial
  begin
    lvl_r = '0;
    se_evt = '0;
  end

  // One pulse cycle after an optional gap, so the model can answer promptly or slowly.
  // Data fields are inverted afterwards, so a design that keeps reading stale data shows it.
  task automatic fire(input usbesu_evt_t e, input int gap);
    usbesu_evt_t q;
    repeat (gap) @(posedge clk);
    @(posedge clk);
    se_evt <= e | lvl_r;
    @(posedge clk);
    q = lvl_r;
    q.tok_stat = ~e.tok_stat;
    q.pid = ~e.pid;
    q.bit_rem = ~e.bit_rem;
    q.buf_addr = ~e.buf_addr;
    se_evt <= q;
  endtask

  // Sets the line levels, which stay until changed again.
  task automatic level(input usbesu_evt_t l);
    @(posedge clk);
    lvl_r = l;
    se_evt <= l;
  endtask
endmodule

// ### testbench.sv
// Self-checking bench for the USB event and status unit.
// Assumes the serial engine model beside it and APB byte addresses at four times the index.
`timescale 1ns/1ps
module testbench;
  import usbesu_pkg::*;
  // ************************************************************
  // Clock, reset and wiring
  // ************************************************************
  localparam int IDLE_SIM = 50; // Short idle count keeps the run brief.
  logic clk = 1'b0; // Core clock.
  logic rst = 1'b1; // Synchronous reset.
  logic psel = 1'b0; // APB select.
  logic penable = 1'b0; // APB enable.
  logic pwrite = 1'b0; // APB direction.
  logic [11:0] paddr = 12'h000; // APB byte address.
  logic [31:0] pwdata = 32'h00000000; // APB write data.
  logic cpu_wr = 1'b0; // Processor buffer write.
  logic [5:0] cpu_addr = 6'h00; // Its location.
  logic [31:0] prdata; // Read data.
  logic pready, pslverr, grant, rel, irq, susp, oe; // Other outputs.
  usbesu_evt_t se_evt; // Driven by the model.
  usbesu_evt_t e; // Event under construction.
  int error_cnt = 0; // Mismatches.
  int checked = 0; // Comparisons.
  int cyc = 0; // Cycle count for the hang guard.

  // Free running 125 MHz clock.
  always #4 clk = ~clk;

  usbesu_top #(.IDLE_CYCLES(IDLE_SIM)) u_usbesu_top (.CORE_CLK(clk), .RESET(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SE_EVT(se_evt), .CPU_BUF_WR(cpu_wr),
    .CPU_BUF_ADDR(cpu_addr), .BUF_WR_GRANT(grant), .DESC_RELEASE(rel), .USB_IRQ(irq),
    .SUSPEND(susp), .XCVR_OE(oe));
  usbesu_se_model u_usbesu_se_model (.clk(clk), .se_evt(se_evt));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Prints the counts and the verdict, then stops.
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compares one byte; an unknown never matches.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held from setup until pready is sampled high.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
    output logic [7:0] q, output logic er);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register read with compare, and plain write.
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    logic er;
    apb(1'b0, idx, 8'h00, q, er);
    chk(q, exp);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    logic [7:0] q;
    logic er;
    apb(1'b1, idx, d, q, er);
  endtask

  // The request line lags flags by a cycle, so let two edges pass first.
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, {7'h00, exp});
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  // Reset values, a read-only write and an unmapped address.
  task automatic t_regs();
    logic [7:0] q;
    logic er;
    for (int i = 0; i < 6; i++)
      rd(IDX_EVT_FLAGS + 10'(i), RST_FLAGS);
    wr(IDX_STAT_WIN, 8'hFF);
    rd(IDX_STAT_WIN, 8'h00);
    apb(1'b0, 10'h196, 8'h00, q, er);
    chk({7'h00, er}, 8'h01);
    chk(q, 8'h00);
    chk({7'h00, oe}, 8'h01);
  endtask

  // Stall and activity flags, masking and write-zero clearing.
  task automatic t_events();
    e = '0;
    e.stall_sent = 1'b1;
    e.activity = 1'b1;
    u_usbesu_se_model.fire(e, 0);
    rd(IDX_EVT_FLAGS, 8'h24);
    irq_is(1'b0);
    wr(IDX_EVT_EN, 8'h20);
    irq_is(1'b1);
    wr(IDX_EVT_FLAGS, 8'hFF);
    rd(IDX_EVT_FLAGS, 8'h24);
    wr(IDX_EVT_FLAGS, 8'hDF);
    rd(IDX_EVT_FLAGS, 8'h04);
    irq_is(1'b0);
    wr(IDX_EVT_FLAGS, 8'h00);
    wr(IDX_EVT_EN, 8'h00);
  endtask

  // Every error source, the summary bit, turnaround and a buffer clash.
  task automatic t_errors();
    logic [7:0] acc;
    logic [7:0] bits [8] = '{8'h80, 8'h02, 8'h04, 8'h01, 8'h08, 8'h40, 8'h00, 8'h00};
    acc = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      e = '0;
      case (i)
        0: e.bitstuff = 1'b1;
        1: e.crc5_bad = 1'b1;
        2: e.crc16_bad = 1'b1;
        3: {e.pid_vld, e.pid} = {1'b1, 8'h33};
        4: {e.data_end, e.bit_rem} = {1'b1, 3'h3};
        5: e.tok_start = 1'b1;
        6: {e.pid_vld, e.pid} = {1'b1, 8'h3C};
        default: e.data_end = 1'b1;
      endcase
      u_usbesu_se_model.fire(e, 0);
      acc = acc | bits[i];
      rd(IDX_ERR_FLAGS, acc);
    end
    rd(IDX_EVT_FLAGS, 8'h00);
    wr(IDX_ERR_EN, 8'h40);
    rd(IDX_EVT_FLAGS, 8'h02);
    wr(IDX_ERR_EN, 8'h00);
    e = '0;
    e.await_turn = 1'b1;
    e.idle_lvl = 1'b1;
    u_usbesu_se_model.level(e);
    e = '0;
    e.eop = 1'b1;
    u_usbesu_se_model.fire(e, 0);
    e = '0;
    e.bit_tick = 1'b1;
    for (int i = 0; i < 17; i++)
      u_usbesu_se_model.fire(e, 0);
    rd(IDX_ERR_FLAGS, acc);
    u_usbesu_se_model.fire(e, 0);
    rd(IDX_ERR_FLAGS, acc | 8'h10);
    u_usbesu_se_model.level('0);
    for (int i = 0; i < 2; i++)
    begin
      e = '0;
      e.buf_wr = 1'b1;
      e.buf_addr = 6'h05;
      fork
        u_usbesu_se_model.fire(e, 0);
        begin
          @(posedge clk);
          cpu_wr <= 1'b1;
          cpu_addr <= 6'h06 - 6'(i);
          @(posedge clk);
          cpu_wr <= 1'b0;
        end
      join
      @(negedge clk);
      chk({7'h00, grant}, {7'h00, i == 0});
    end
    rd(IDX_ERR_FLAGS, 8'hFF);
    wr(IDX_ERR_FLAGS, 8'h00);
    rd(IDX_ERR_FLAGS, 8'h00);
    wr(IDX_EVT_FLAGS, 8'h00);
  endtask

  // Five tokens into a four-deep queue; firmware reads the window before clearing.
  task automatic t_token();
    for (int i = 0; i < 5; i++)
    begin
      e = '0;
      e.tok_done = 1'b1;
      e.tok_stat = 8'h11 + 8'(i);
      u_usbesu_se_model.fire(e, (i % 2) * 3);
      @(negedge clk);
      chk({7'h00, rel}, 8'h01);
    end
    for (int k = 0; k < 4; k++)
    begin
      rd(IDX_EVT_FLAGS, 8'h08);
      rd(IDX_STAT_WIN, 8'h11 + 8'(k));
      wr(IDX_EVT_FLAGS, 8'hF7);
    end
    rd(IDX_EVT_FLAGS, 8'h00);
    rd(IDX_STAT_WIN, 8'h00);
  endtask

  // Suspend freezes flag writes and leaves only activity able to interrupt.
  task automatic t_suspend();
    e = '0;
    e.stall_sent = 1'b1;
    e.activity = 1'b1;
    u_usbesu_se_model.fire(e, 0);
    wr(IDX_EVT_EN, 8'h24);
    wr(IDX_CTRL, 8'h02);
    irq_is(1'b1);
    chk({6'h00, susp, oe}, 8'h02);
    wr(IDX_EVT_FLAGS, 8'h00);
    rd(IDX_EVT_FLAGS, 8'h24);
    wr(IDX_EVT_EN, 8'h20);
    irq_is(1'b0);
    wr(IDX_CTRL, 8'h00);
    wr(IDX_EVT_EN, 8'h00);
    wr(IDX_EVT_FLAGS, 8'h00);
    rd(IDX_EVT_FLAGS, 8'h00);
  endtask

  // Idle timer restarted by activity, then allowed to expire.
  task automatic t_idle();
    e = '0;
    e.idle_lvl = 1'b1;
    u_usbesu_se_model.level(e);
    repeat (IDLE_SIM - 10) @(posedge clk);
    e.activity = 1'b1;
    u_usbesu_se_model.fire(e, 0);
    repeat (IDLE_SIM - 10) @(posedge clk);
    rd(IDX_EVT_FLAGS, 8'h04);
    repeat (15) @(posedge clk);
    rd(IDX_EVT_FLAGS, 8'h14);
    u_usbesu_se_model.level('0);
    wr(IDX_EVT_FLAGS, 8'h00);
  endtask

  // Bus reset flags once per reset, and again after a fresh one.
  task automatic t_reset();
    e = '0;
    e.reset_lvl = 1'b1;
    u_usbesu_se_model.level(e);
    repeat (RST_CYC + 8) @(posedge clk);
    rd(IDX_EVT_FLAGS, 8'h01);
    wr(IDX_EVT_FLAGS, 8'h00);
    repeat (RST_CYC + 8) @(posedge clk);
    rd(IDX_EVT_FLAGS, 8'h00);
    u_usbesu_se_model.level('0);
    u_usbesu_se_model.level(e);
    repeat (RST_CYC + 8) @(posedge clk);
    rd(IDX_EVT_FLAGS, 8'h01);
  endtask

  // ************************************************************
  // Main sequence and hang guard
  // ************************************************************
  // Reset for four cycles, then every scenario in turn.
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_events();
    t_errors();
    t_token();
    t_suspend();
    t_idle();
    t_reset();
    test_done();
  end

  // The whole run needs about fourteen hundred cycles; this ceiling leaves a wide margin.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      test_done();
    end
  end
endmodule
